//--- core/dram_ctrl.sv
// host-side controller driving a 64k x 4 multiplexed-address dram
`timescale 1ns/10ps
`include "dram_defines.svh"

module dram_ctrl
    import dram_pkg::*;
#(
    parameter int INIT_CYCLES = `DRAM_INIT_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [3:0]  req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [3:0]       rsp_rdata,
    output logic             init_done,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic             oe_n,
    output logic [7:0]       mux_address,
    input  wire logic [3:0]  data_io_in,
    output logic [3:0]       data_io_out,
    output logic             data_io_oe_n
);

    // cycle counts at the controller clock
    localparam logic [14:0] RAH_C  = 15'(`DRAM_RAH_CYC);
    localparam logic [14:0] RCD_C  = 15'(`DRAM_RCD_CYC);
    localparam int          RASL_I = `DRAM_RAC_CYC + `DRAM_SYNC_STAGES + 1;
    localparam int          RAS_I  = `DRAM_CEIL(`DRAM_RAS_NS);
    // ras low long enough for both pulse width and synced access
    localparam logic [14:0] RASL_C = 15'((RASL_I > RAS_I) ? RASL_I : RAS_I);
    // precharge stretched so the whole cycle covers the random cycle
    localparam int          PRE_I  = (`DRAM_RC_CYC - RASL_I > `DRAM_RP_CYC)
                                     ? `DRAM_RC_CYC - RASL_I : `DRAM_RP_CYC;
    localparam logic [14:0] PRE_C  = 15'(PRE_I);
    localparam logic [14:0] INIT_C = 15'(INIT_CYCLES);
    localparam logic [10:0] REF_C  = 11'(`DRAM_REF_CYC);
    localparam logic [3:0]  NRAS_C = 4'(`DRAM_INIT_RAS);

    ctrl_s q;
    ctrl_s d;

    // next-state logic for the whole controller
    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        // pin input passes two flops before use
        d.dq_s1 = data_io_in;
        d.dq_s2 = q.dq_s1;

        // refresh timer runs from reset; pending flag set wins over clear
        if (q.ref_cnt == REF_C - 11'h001) begin
            d.ref_cnt = 11'h000;
            d.ref_pend = 1'b1;
        end else begin
            d.ref_cnt = q.ref_cnt + 11'h001;
        end

        unique case (q.st)
            ST_INIT: begin
                // power-up pause before any strobe moves
                if (q.cnt == INIT_C - 15'h0001) begin
                    d.cnt = 15'h0000;
                    d.op = OP_REFRESH;
                    d.init_left = NRAS_C;
                    d.maddr = q.ref_row;
                    d.st = ST_SETUP;
                end else begin
                    d.cnt = q.cnt + 15'h0001;
                end
            end
            ST_IDLE: begin
                d.cnt = 15'h0000;
                // refresh has priority over user accesses
                if (q.ref_pend) begin
                    d.ref_pend = (d.ref_cnt == 11'h000);
                    d.op = OP_REFRESH;
                    d.maddr = q.ref_row;
                    d.st = ST_SETUP;
                end else if (req_valid && q.req_ready) begin
                    d.op = req_write ? OP_WRITE : OP_READ;
                    d.addr = req_addr;
                    d.wdata = req_wdata;
                    d.maddr = req_addr[15:8];
                    d.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // row address has stood a cycle; now the row strobe falls
                d.ras_n = 1'b0;
                d.st = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                d.cnt = q.cnt + 15'h0001;
                // column address after row hold time
                if (q.cnt == RAH_C - 15'h0001 && q.op != OP_REFRESH) begin
                    d.maddr = q.addr[7:0];
                    if (q.op == OP_WRITE) begin
                        // early write: we low and data before column strobe
                        d.we_n = 1'b0;
                        d.dq_out = q.wdata;
                        d.dq_oe_n = 1'b0;
                    end else begin
                        d.oe_n = 1'b0;
                    end
                end
                // column strobe inside the multiplex window
                if (q.cnt == RCD_C - 15'h0001 && q.op != OP_REFRESH) begin
                    d.cas_n = 1'b0;
                end
                if (q.cnt == RASL_C - 15'h0001) begin
                    // synced sample taken from a pin settled since access
                    if (q.op == OP_READ) begin
                        d.rdata = q.dq_s2;
                        d.rsp_valid = 1'b1;
                    end
                    // both strobes rise together, we high already on reads
                    d.ras_n = 1'b1;
                    d.cas_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.cnt = 15'h0000;
                    d.st = ST_PRE;
                    if (q.op == OP_REFRESH) begin
                        d.ref_row = q.ref_row + 8'h01;
                    end
                end
            end
            ST_PRE: begin
                d.cnt = q.cnt + 15'h0001;
                // data held past strobe rise, then released
                d.we_n = 1'b1;
                d.dq_oe_n = 1'b1;
                // read level held through precharge covers both holds
                if (q.cnt == PRE_C - 15'h0001) begin
                    d.cnt = 15'h0000;
                    if (q.init_left > 4'h1) begin
                        d.init_left = q.init_left - 4'h1;
                        d.maddr = d.ref_row;
                        d.op = OP_REFRESH;
                        d.st = ST_SETUP;
                    end else begin
                        d.init_left = 4'h0;
                        d.init_done = 1'b1;
                        d.st = ST_IDLE;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // precharge outlasts device turn-off, so no bus contention
        d.req_ready = (d.st == ST_IDLE) && d.init_done && !d.ref_pend
                      && (PRE_C >= 15'(`DRAM_OFF_CYC));
    end

    // single state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '{st: ST_INIT, op: OP_READ, cnt: 15'h0000,
                   ref_cnt: 11'h000, ref_pend: 1'b0, ref_row: 8'h00,
                   init_left: 4'h0, init_done: 1'b0, addr: 16'h0000,
                   wdata: 4'h0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                   oe_n: 1'b1, maddr: 8'h00, dq_out: 4'h0,
                   dq_oe_n: 1'b1, dq_s1: 4'h0, dq_s2: 4'h0,
                   rdata: 4'h0, rsp_valid: 1'b0, req_ready: 1'b0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign req_ready    = q.req_ready;
    assign rsp_valid    = q.rsp_valid;
    assign rsp_rdata    = q.rdata;
    assign init_done    = q.init_done;
    assign ras_n        = q.ras_n;
    assign cas_n        = q.cas_n;
    assign we_n         = q.we_n;
    assign oe_n         = q.oe_n;
    assign mux_address  = q.maddr;
    assign data_io_out  = q.dq_out;
    assign data_io_oe_n = q.dq_oe_n;

endmodule

//--- core/dram_defines.svh
// timing and geometry constants for the dram host controller
`ifndef DRAM_DEFINES_SVH
`define DRAM_DEFINES_SVH

`define DRAM_CLK_PS        8000
`define DRAM_INIT_US       200
`define DRAM_INIT_RAS      8
`define DRAM_RC_NS         190
`define DRAM_RP_NS         80
`define DRAM_RAS_NS        100
`define DRAM_RAH_NS        10
`define DRAM_RCD_MIN_NS    20
`define DRAM_RCD_MAX_NS    50
`define DRAM_RAC_NS        100
`define DRAM_OFF_NS        30
`define DRAM_RRH_NS        10
`define DRAM_RFSH_US       4000
`define DRAM_ROWS          256
`define DRAM_SYNC_STAGES   2

// least times round up, longest times round down
`define DRAM_CEIL(ns)  (((ns) * 1000 + `DRAM_CLK_PS - 1) / `DRAM_CLK_PS)
`define DRAM_FLOOR(ns) (((ns) * 1000) / `DRAM_CLK_PS)

`define DRAM_INIT_CYC  (`DRAM_INIT_US * 1000 * 1000 / `DRAM_CLK_PS)
`define DRAM_RAH_CYC   `DRAM_CEIL(`DRAM_RAH_NS)
`define DRAM_RCD_CYC   `DRAM_CEIL(`DRAM_RCD_MIN_NS)
`define DRAM_RCDX_CYC  `DRAM_FLOOR(`DRAM_RCD_MAX_NS)
`define DRAM_RAC_CYC   `DRAM_CEIL(`DRAM_RAC_NS)
`define DRAM_RP_CYC    `DRAM_CEIL(`DRAM_RP_NS)
`define DRAM_RC_CYC    `DRAM_CEIL(`DRAM_RC_NS)
`define DRAM_OFF_CYC   `DRAM_CEIL(`DRAM_OFF_NS)
// period in ns over clock in ns; a ps product would overflow 32 bits
`define DRAM_REF_CYC   ((`DRAM_RFSH_US * 1000 / (`DRAM_CLK_PS / 1000)) \
                        / `DRAM_ROWS)

`endif

//--- core/dram_pkg.sv
// types shared by the dram host controller
package dram_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_ACTIVE = 3'b011,
        ST_PRE    = 3'b010,
        ST_INIT   = 3'b110
    } state_e;

    typedef enum logic [1:0] {
        OP_READ    = 2'h0,
        OP_WRITE   = 2'h1,
        OP_REFRESH = 2'h2
    } op_e;

    typedef struct packed {
        state_e      st;
        op_e         op;
        logic [14:0] cnt;
        logic [10:0] ref_cnt;
        logic        ref_pend;
        logic [7:0]  ref_row;
        logic [3:0]  init_left;
        logic        init_done;
        logic [15:0] addr;
        logic [3:0]  wdata;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        oe_n;
        logic [7:0]  maddr;
        logic [3:0]  dq_out;
        logic        dq_oe_n;
        logic [3:0]  dq_s1;
        logic [3:0]  dq_s2;
        logic [3:0]  rdata;
        logic        rsp_valid;
        logic        req_ready;
    } ctrl_s;

endpackage

//--- tb/dram_ctrl_chk.sv
// pin-level assertions for the dram host controller
`timescale 1ns/10ps
module dram_ctrl_chk #(
    parameter int INIT_CYCLES = 20
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       init_done,
    input wire logic       ras_n,
    input wire logic       cas_n,
    input wire logic       we_n,
    input wire logic       oe_n,
    input wire logic [7:0] mux_address,
    input wire logic [3:0] data_io_out,
    input wire logic       data_io_oe_n
);
    localparam int GAP_MAX = 1990;
    logic [14:0] up_q;
    logic [10:0] gap_q;
    logic [3:0]  nras_q;
    // saturating counts: since reset, since last row fall, row falls
    always_ff @(posedge mclk) begin
        if (rst) begin
            up_q <= '0;
            gap_q <= '1;
            nras_q <= '0;
        end else begin
            up_q <= up_q + 15'(up_q != '1);
            gap_q <= $fell(ras_n) ? '0 : gap_q + 11'(gap_q != '1);
            nras_q <= nras_q + 4'($fell(ras_n) && nras_q != '1);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_init_wait: assert property (
        $fell(ras_n) |-> up_q >= INIT_CYCLES)
        else $error("row strobe before power-up pause");
    a_init_count: assert property ($rose(init_done) |-> nras_q >= 8)
        else $error("init done before eight row cycles");
    a_early_cas: assert property ($fell(cas_n) |-> nras_q >= 8)
        else $error("column access before wake-up cycles");
    a_ras_gap: assert property ($fell(ras_n) |-> gap_q >= 23)
        else $error("row strobe falls too close");
    a_refresh_gap: assert property (init_done |-> gap_q < GAP_MAX)
        else $error("refresh interval overrun");
    a_row_hold: assert property (
        $fell(ras_n) |-> ##1 $stable(mux_address))
        else $error("row address not held");
    a_cas_order: assert property (
        $fell(cas_n) |-> !ras_n && $stable(ras_n))
        else $error("column strobe without row strobe");
    a_read_hold: assert property ($rose(cas_n) && we_n |-> we_n[*3])
        else $error("write enable dropped after read");
    a_wdata_hold: assert property ($fell(cas_n) && !we_n
        |-> (!data_io_oe_n && $stable(data_io_out))[*4])
        else $error("write data not held after column fall");
    // early write: output enable off, write enable falls before column
    a_write_oe: assert property (
        !we_n |-> oe_n && (cas_n || !$fell(we_n)))
        else $error("output enable or late write seen");
endmodule

bind dram_ctrl dram_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_inst (
    .mclk, .rst, .init_done, .ras_n, .cas_n, .we_n, .oe_n,
    .mux_address, .data_io_out, .data_io_oe_n);

//--- tb/dram_model.sv
// behavioural 64k x 4 dram standing at the controller pins
`timescale 1ns/10ps
module dram_model (
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic       oe_n,
    input  wire logic [7:0] addr,
    input  wire logic [3:0] din,
    output logic      [3:0] q
);
    logic [3:0]  mem [0:65535];
    logic [7:0]  row;
    logic [15:0] idx;
    realtime     t_ras;
    realtime     d;
    initial q = 4'h0;
    // row half latched on the row strobe fall
    always @(negedge ras_n) begin
        row = addr;
        t_ras = $realtime;
    end
    // junk until the slower access path has run out, never early
    always @(negedge cas_n) begin
        idx = {row, addr};
        if (!ras_n && !we_n) begin
            mem[idx] = din;
        end else if (!ras_n && !oe_n) begin
            q = ~mem[idx];
            d = t_ras + 100 - $realtime;
            if (d < 50)
                d = 50;
            #d q = mem[idx];
        end
    end
    // released at the latest allowed moment; inverted so no stale match
    always @(posedge cas_n) #30 q = ~q;
endmodule

//--- tb/dram_ctrl_tb.sv
// self-checking bench for the dram host controller
`timescale 1ns/10ps
module dram_ctrl_tb;
    localparam int INIT = 20;
    logic        mclk = 0, rst = 1, req_valid = 0, req_write = 0;
    logic [15:0] req_addr = '0;
    logic [3:0]  req_wdata = '0, data_io_out, data_io_in, dev_q, rsp_rdata;
    logic        req_ready, rsp_valid, init_done, ras_n, cas_n, we_n, oe_n;
    logic        data_io_oe_n;
    logic [7:0]  mux_address;
    int          err_total = 0, checked = 0;
    // shared pin level: controller wins while it drives
    assign data_io_in = !data_io_oe_n ? data_io_out : dev_q;
    dram_ctrl #(.INIT_CYCLES(INIT)) dram_ctrl_inst (.mclk, .rst, .req_valid,
        .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
        .init_done, .ras_n, .cas_n, .we_n, .oe_n, .mux_address, .data_io_in,
        .data_io_out, .data_io_oe_n);
    dram_model dram_model_inst (.ras_n, .cas_n, .we_n, .oe_n,
        .addr(mux_address), .din(data_io_in), .q(dev_q));
    initial forever #4 mclk = ~mclk;
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // reset, then count the wake-up row cycles
    task automatic init_test;
        int n = 0, falls = 0, first = -1;
        logic prev = 1;
        rst = 1;
        repeat (8) @(negedge mclk);
        rst = 0;
        while (init_done !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
            if (prev && !ras_n && first < 0)
                first = n;
            if (prev && !ras_n)
                falls++;
            prev = ras_n;
        end
        check(falls == 8, "wake-up row cycles");
        check(first >= INIT, "power-up pause");
        $display("init test done");
    endtask
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [3:0] d, output int n);
        n = 0;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        check(n < 3000, "request not taken");
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge mclk);
        req_valid = 0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
    endtask
    // corners and swapped row/column halves, read back to back
    task automatic rw_test;
        logic [15:0] a[4] = '{16'h0000, 16'hffff, 16'h12ab, 16'hab12};
        int lat;
        for (int i = 0; i < 4; i++)
            access(1, a[i], 4'h3 + 4'(4 * i), lat);
        for (int i = 0; i < 4; i++) begin
            access(0, a[i], 4'h0, lat);
            check(rsp_rdata === 4'h3 + 4'(4 * i), "read data");
            // one setup cycle, then sixteen cycles of row strobe low
            check(lat == 17, "read latency");
        end
        $display("read write test done");
    endtask
    // idle: refresh rows must step by one inside the interval
    task automatic refresh_test;
        logic [7:0] r0;
        int n = 0, t0 = -1;
        logic prev = 1;
        while (n < 4500) begin
            @(negedge mclk);
            n++;
            if (prev && !ras_n) begin
                check(cas_n === 1'b1, "refresh column strobe");
                if (t0 >= 0) begin
                    check(mux_address === r0 + 8'h01, "refresh row");
                    check(n - t0 <= 1953, "refresh spacing");
                    break;
                end
                t0 = n;
                r0 = mux_address;
            end
            prev = ras_n;
        end
        check(n < 4500, "two refreshes seen");
        $display("refresh test done");
    endtask
    initial begin
        init_test();
        rw_test();
        refresh_test();
        init_test(); // second reset mid-run
        rw_test();
        end_of_test();
    end
    // the tests need about 4400 cycles
    initial begin
        #(20000 * 8);
        err_total++;
        $display("wrong value at %0t: watchdog ran out", $time);
        end_of_test();
    end
endmodule
